/* File: shared/cld_pkg.sv */
// Package for the charge limit DAC control block: map, codes, ceilings, timing
package cld_pkg;
    // Register byte addresses
    localparam logic [7:0] CLD_REG_VOLT_REQ = 8'h00;
    localparam logic [7:0] CLD_REG_CURR_REQ = 8'h04;
    localparam logic [7:0] CLD_REG_OPTION = 8'h08;
    localparam logic [7:0] CLD_REG_STATUS = 8'h0C;
    localparam logic [7:0] CLD_REG_VDAC = 8'h10;
    localparam logic [7:0] CLD_REG_IDAC = 8'h14;
    // Option bits
    localparam int CLD_OPT_NO_LOW_BIT = 0;
    localparam int CLD_OPT_WAKE_BIT = 1;
    // Status bits
    localparam int CLD_ST_VOR_BIT = 0;
    localparam int CLD_ST_PWRLOST_BIT = 1;
    localparam int CLD_ST_LOWMODE_BIT = 2;
    localparam int CLD_ST_CHARGE_ENABLE_PIN_BIT = 3;
    localparam int CLD_ST_ICLASS_LSB = 4;
    localparam int CLD_ST_VCLASS_LSB = 8;
    // AXI responses
    localparam logic [1:0] CLD_RESP_OKAY = 2'h0;
    localparam logic [1:0] CLD_RESP_SLVERR = 2'h2;
    // Current ceilings in mA per select class, and step per class
    localparam logic [15:0] CLD_CURRENT_CEILING_SELECT_MA [4] = '{16'h03FF, 16'h07FE, 16'h0BFC, 16'h0FFC};
    localparam logic [2:0] CLD_ISTEP_MA [4] = '{3'h1, 3'h2, 3'h4, 3'h4};
    // Voltage ceilings in mV per select class
    localparam logic [15:0] CLD_VOLTAGE_CEILING_SELECT_MV [5] =
        '{16'h2260, 16'h3330, 16'h4400, 16'h54D0, 16'h6D60};
    localparam logic [15:0] CLD_VMIN_MV = 16'h0B54;   // 2900 mV floor of range
    localparam logic [15:0] CLD_VSTEP_MV = 16'h0010;  // 16 mV step
    localparam logic [15:0] CLD_VREF_MV = 16'h04A0;   // 1184 mV reference
    localparam logic [15:0] CLD_WAKE_MA = 16'h0050;   // 80 mA wake current
    localparam int CLD_LOW_DIV = 16;                  // Low mode below 1/16 of ceiling
    localparam int CLD_PWM_DUTY_DEN = 8;              // 1/8 duty gate
    localparam int CLD_FSIG_W = 12;                   // Delta-sigma code width
    // Timing
    localparam int CLD_CLK_HZ = 20000000;
    localparam int CLD_SLOW_BIT_MS = 45;
    localparam int CLD_SLOW_BIT_CYC = (CLD_CLK_HZ / 1000) * CLD_SLOW_BIT_MS;
endpackage

/* File: shared/cld_dsm_if.sv */
// Interface between the top and the delta-sigma modulator
`timescale 1ns/1ps
`default_nettype none
interface cld_dsm_if;
    logic [11:0] code;
    logic [11:0] full;
    logic step;
    logic bit_out;
    modport ctrl (output code, output full, output step, input bit_out);
    modport dsm (input code, input full, input step, output bit_out);
endinterface
`default_nettype wire

/* File: logic/cld_dsm.sv */
// First-order delta-sigma modulator, advanced by a step enable
`timescale 1ns/1ps
`default_nettype none
module cld_dsm (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Modulator link
    cld_dsm_if.dsm dsm
);
    import cld_pkg::*;

    logic [12:0] acc_q;
    logic [12:0] sum;
    logic bit_q;

    // Reaching or passing full scale emits a one and wraps
    always_comb begin
        sum = acc_q + {1'b0, dsm.code};
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            acc_q <= 13'h0000;
            bit_q <= 1'b0;
        end else if (dsm.step) begin
            if (sum >= {1'b0, dsm.full}) begin
                acc_q <= sum - {1'b0, dsm.full};
                bit_q <= 1'b1;
            end else begin
                acc_q <= sum;
                bit_q <= 1'b0;
            end
        end
    end

    assign dsm.bit_out = bit_q;
endmodule
`default_nettype wire

/* File: logic/cld_top.sv */
// Charge limit DAC control: ceilings, voltage DAC code, current delta-sigma, input FET
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cld_top
    import cld_pkg::*;
#(
    parameter int SLOW_BIT_CYC = CLD_SLOW_BIT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Decoded select pin classes from the analog window comparators
    input wire logic [1:0] current_ceiling_select,
    input wire logic [2:0] voltage_ceiling_select,
    // Input FET comparators: above +130 mV, above +25 mV, below -25 mV
    input wire logic adapter_above_130,
    input wire logic adapter_above_25,
    input wire logic adapter_below_neg25,
    // Charge enable pin, open drain
    input wire logic charge_enable_pin_in,
    output logic charge_enable_pin_out,
    output logic charge_enable_pin_oe,
    // Input FET gate control
    output logic fet_on,
    output logic fet_off_slow,
    output logic fet_off_fast,
    // DAC outputs
    output logic [15:0] vdac_code,
    output logic idac_switch,
    output logic low_current_mode,
    output logic charging_active
);
    import cld_pkg::*;

    typedef enum logic [1:0] {
        CLD_FET_OFF = 2'b00,
        CLD_FET_ON = 2'b01,
        CLD_FET_SLOW = 2'b11,
        CLD_FET_FAST = 2'b10
    } cld_fet_e;

    // Pin synchronisers
    logic [1:0] ics_m_q, ics_q;
    logic [2:0] vcs_m_q, vcs_q;
    logic [3:0] cmp_m_q, cmp_q;
    logic [3:0] cmp_raw;
    assign cmp_raw = {charge_enable_pin_in, adapter_below_neg25, adapter_above_25,
                      adapter_above_130};

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ics_m_q <= 2'h0;
            ics_q <= 2'h0;
            vcs_m_q <= 3'h0;
            vcs_q <= 3'h0;
            cmp_m_q <= 4'h8;
            cmp_q <= 4'h8;
        end else begin
            ics_m_q <= current_ceiling_select;
            ics_q <= ics_m_q;
            vcs_m_q <= voltage_ceiling_select;
            vcs_q <= vcs_m_q;
            cmp_m_q <= cmp_raw;
            cmp_q <= cmp_m_q;
        end
    end

    // Software registers
    logic [15:0] volt_req_q, curr_req_q;
    logic [1:0] option_q;
    logic vor_q;

    // Ceilings; the 5th+ voltage codes clamp to the top class
    logic [15:0] current_ceiling_select_ma, voltage_ceiling_select_mv;
    logic [2:0] vsel;
    assign vsel = (vcs_q > 3'h4) ? 3'h4 : vcs_q;
    assign current_ceiling_select_ma = CLD_CURRENT_CEILING_SELECT_MA[ics_q];
    assign voltage_ceiling_select_mv = CLD_VOLTAGE_CEILING_SELECT_MV[vsel];

    // Voltage DAC code
    logic [15:0] vclamp, vtarget;
    logic vover;
    always_comb begin
        vover = volt_req_q > voltage_ceiling_select_mv;
        vclamp = vover ? voltage_ceiling_select_mv : volt_req_q;
        // whole 16 mV steps above the 2900 mV floor
        // A clamped request lands on the ceiling itself, which need not sit on a step
        if (!vover && vclamp >= CLD_VMIN_MV) begin
            vtarget = vclamp - ((vclamp - CLD_VMIN_MV) % CLD_VSTEP_MV);
        end else begin
            vtarget = vclamp;
        end
    end

    // Current DAC code, in ceiling steps
    logic [15:0] ireq, isat;
    logic [11:0] icode, ifull;
    logic low_want;
    always_comb begin
        // wake current replaces the request; class ceiling and step still apply
        ireq = option_q[CLD_OPT_WAKE_BIT] ? CLD_WAKE_MA : curr_req_q;
        isat = (ireq >= current_ceiling_select_ma) ? current_ceiling_select_ma : ireq;
        // duty is request over ceiling, both in steps
        icode = 12'(isat / 16'(CLD_ISTEP_MA[ics_q]));
        ifull = 12'(current_ceiling_select_ma / 16'(CLD_ISTEP_MA[ics_q]));
        // below one sixteenth of the ceiling
        low_want = (isat < 16'(current_ceiling_select_ma / 16'(CLD_LOW_DIV)))
                 && !option_q[CLD_OPT_NO_LOW_BIT];
    end

    // Input FET state machine
    cld_fet_e fet_q;
    logic ext_low;
    assign ext_low = !cmp_q[3] && charge_enable_pin_oe == 1'b0;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            fet_q <= CLD_FET_OFF;
        end else begin
            unique case (fet_q)
                CLD_FET_OFF: if (cmp_q[0] && !cmp_q[2]) fet_q <= CLD_FET_ON;
                CLD_FET_ON: begin
                    if (cmp_q[2]) fet_q <= CLD_FET_FAST;
                    else if (!cmp_q[1]) fet_q <= CLD_FET_SLOW;
                end
                CLD_FET_SLOW: begin
                    if (cmp_q[2]) fet_q <= CLD_FET_FAST;
                    else if (cmp_q[1]) fet_q <= CLD_FET_ON;
                end
                CLD_FET_FAST: if (!cmp_q[2]) fet_q <= CLD_FET_OFF;
            endcase
        end
    end

    logic fet_good;
    // one condition feeds pin and flag
    assign fet_good = (fet_q == CLD_FET_ON) || (fet_q == CLD_FET_SLOW);

    // Charge enable drive; released only while input is good
    always_ff @(posedge clk) begin
        if (!rstn) begin
            charge_enable_pin_out <= 1'b0;
            charge_enable_pin_oe <= 1'b1;
            fet_on <= 1'b0;
            fet_off_slow <= 1'b0;
            fet_off_fast <= 1'b0;
        end else begin
            charge_enable_pin_out <= 1'b0;
            charge_enable_pin_oe <= !fet_good;
            fet_on <= fet_q == CLD_FET_ON;
            fet_off_slow <= fet_q == CLD_FET_SLOW;
            fet_off_fast <= fet_q == CLD_FET_FAST;
        end
    end

    // Charging qualified by input and by the pin as seen outside
    logic chg_ok;
    // external low stops; stored requests are kept for resume
    assign chg_ok = fet_good && !ext_low && cmp_q[3];

    // Slow step divider for low mode; fast 1/8 gate counter
    logic [31:0] slow_cnt_q;
    logic slow_step;
    logic [2:0] pwm_q;
    assign slow_step = slow_cnt_q == 32'(SLOW_BIT_CYC - 1);
    always_ff @(posedge clk) begin
        if (!rstn || !low_current_mode) begin
            slow_cnt_q <= 32'h0;
        end else if (slow_step) begin
            slow_cnt_q <= 32'h0;
        end else begin
            slow_cnt_q <= slow_cnt_q + 32'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pwm_q <= 3'h0;
        end else begin
            pwm_q <= pwm_q + 3'h1;
        end
    end

    cld_dsm_if dsm_l ();
    assign dsm_l.code = icode;
    assign dsm_l.full = (ifull == 12'h000) ? 12'h001 : ifull;
    // slow advance in low mode, every clock otherwise
    assign dsm_l.step = low_current_mode ? slow_step : 1'b1;

    cld_dsm u_dsm (
        .clk(clk),
        .rstn(rstn),
        .dsm(dsm_l.dsm)
    );

    // DAC outputs and over-range flag
    always_ff @(posedge clk) begin
        if (!rstn) begin
            vdac_code <= 16'h0000;
            idac_switch <= 1'b0;
            low_current_mode <= 1'b0;
            charging_active <= 1'b0;
            vor_q <= 1'b0;
        end else begin
            low_current_mode <= low_want;
            charging_active <= chg_ok;
            vor_q <= vover;
            if (!chg_ok || vtarget < CLD_VREF_MV) begin
                vdac_code <= 16'h0000;
            end else begin
                vdac_code <= vtarget - CLD_VREF_MV;
            end
            if (!chg_ok) begin
                idac_switch <= 1'b0;
            end else if (low_current_mode) begin
                idac_switch <= dsm_l.bit_out && (pwm_q == 3'(CLD_PWM_DUTY_DEN - 1));
            end else begin
                idac_switch <= dsm_l.bit_out;
            end
        end
    end

    // AXI4-Lite write: take address and data in any order, answer after both
    logic aw_got_q, w_got_q;
    logic [7:0] aw_q;
    logic [31:0] wd_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CLD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wd_q <= s_axi_wdata;
            end
            if (aw_got_q && w_got_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_q == CLD_REG_VOLT_REQ || aw_q == CLD_REG_CURR_REQ
                                || aw_q == CLD_REG_OPTION) ? CLD_RESP_OKAY : CLD_RESP_SLVERR;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_got_q && !s_axi_bvalid && rstn;
    assign s_axi_wready = !w_got_q && !s_axi_bvalid && rstn;

    // Register writes; low half only, strobes honoured per byte
    logic wr_fire;
    assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            volt_req_q <= 16'h0000;
            curr_req_q <= 16'h0000;
            option_q <= 2'h0;
        end else if (wr_fire) begin
            if (aw_q == CLD_REG_VOLT_REQ) begin
                if (s_axi_wstrb[0]) volt_req_q[7:0] <= wd_q[7:0];
                if (s_axi_wstrb[1]) volt_req_q[15:8] <= wd_q[15:8];
            end
            if (aw_q == CLD_REG_CURR_REQ) begin
                if (s_axi_wstrb[0]) curr_req_q[7:0] <= wd_q[7:0];
                if (s_axi_wstrb[1]) curr_req_q[15:8] <= wd_q[15:8];
            end
            if (aw_q == CLD_REG_OPTION && s_axi_wstrb[0]) begin
                option_q <= wd_q[1:0];
            end
        end
    end

    // Status word
    logic [31:0] status_w, rd_mux;
    always_comb begin
        status_w = 32'h0;
        status_w[CLD_ST_VOR_BIT] = vor_q;
        status_w[CLD_ST_PWRLOST_BIT] = !fet_good;
        status_w[CLD_ST_LOWMODE_BIT] = low_current_mode;
        status_w[CLD_ST_CHARGE_ENABLE_PIN_BIT] = cmp_q[3];
        status_w[CLD_ST_ICLASS_LSB +: 2] = ics_q;
        status_w[CLD_ST_VCLASS_LSB +: 3] = vcs_q;
        unique case (s_axi_araddr)
            CLD_REG_VOLT_REQ: rd_mux = {16'h0, volt_req_q};
            CLD_REG_CURR_REQ: rd_mux = {16'h0, curr_req_q};
            CLD_REG_OPTION: rd_mux = {30'h0, option_q};
            CLD_REG_STATUS: rd_mux = status_w;
            CLD_REG_VDAC: rd_mux = {16'h0, vdac_code};
            CLD_REG_IDAC: rd_mux = {20'h0, icode};
            default: rd_mux = 32'h0;
        endcase
    end

    // AXI4-Lite read: one cycle to data
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= CLD_RESP_OKAY;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= (s_axi_araddr <= CLD_REG_IDAC && s_axi_araddr[1:0] == 2'h0)
                               ? CLD_RESP_OKAY : CLD_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Over-range flag follows the clamp one cycle later
    // flag tied to clamp
    a_vor_flag: assert property (@(posedge clk) disable iff (!rstn)
        (volt_req_q > voltage_ceiling_select_mv) |=> vor_q)
        else $error("over-range flag not set");
    a_vdac_offset: assert property (@(posedge clk) disable iff (!rstn)
        (chg_ok && vtarget >= CLD_VREF_MV) |=> vdac_code == $past(vtarget) - CLD_VREF_MV)
        else $error("voltage code offset wrong");
    a_vdac_zero: assert property (@(posedge clk) disable iff (!rstn)
        (vtarget < CLD_VREF_MV) |=> vdac_code == 16'h0000)
        else $error("voltage code not zero");
    a_icode_ceil: assert property (@(posedge clk) disable iff (!rstn)
        icode <= ifull)
        else $error("current code above ceiling");
    a_low_block: assert property (@(posedge clk) disable iff (!rstn)
        option_q[CLD_OPT_NO_LOW_BIT] |=> !low_current_mode)
        else $error("low mode while disabled");
    // gated pulse at most one in eight
    a_low_duty: assert property (@(posedge clk) disable iff (!rstn)
        (low_current_mode && $past(low_current_mode) && idac_switch) |=> !idac_switch[*7])
        else $error("low mode duty above one eighth");
    a_rev_pin: assert property (@(posedge clk) disable iff (!rstn)
        (fet_q == CLD_FET_FAST) |=> charge_enable_pin_oe && !charge_enable_pin_out)
        else $error("charge enable not driven low");
    a_ext_stop: assert property (@(posedge clk) disable iff (!rstn)
        !chg_ok |=> !idac_switch && !charging_active)
        else $error("charging while stopped");
endmodule
`default_nettype wire

/* File: testbench/cld_fe_model.sv */
// Front-end model: input FET comparators and the open-drain charge-enable wire
`timescale 1ns/1ps
`default_nettype none
module cld_fe_model (
    // Adapter-to-sense difference and outside pull
    input wire logic signed [15:0] diff_mv,
    input wire logic ext_pull_low,
    // Device pull on the pin
    input wire logic dev_pull_low,
    // Comparator levels and wire level
    output logic cmp_130,
    output logic cmp_25,
    output logic cmp_neg25,
    output logic pin_level
);
    assign cmp_130 = diff_mv > 16'sh0082;
    assign cmp_25 = diff_mv > 16'sh0019;
    assign cmp_neg25 = diff_mv < -16'sh0019;
    // Pulled up; low while either party pulls, never left floating
    assign pin_level = !(dev_pull_low || ext_pull_low);
endmodule
`default_nettype wire

/* File: testbench/cld_top_tb.sv */
// Self-checking bench for the charge limit DAC control block
`timescale 1ns/1ps
`default_nettype none
module cld_top_tb;
    import cld_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, ext = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [1:0] isel = 2'h0;
    logic [2:0] vsel = 3'h0;
    logic signed [15:0] diff = 16'sh0000;
    logic awready, wready, bvalid, arready, rvalid, c130, c25, cn25, pin;
    logic oe, fet_on, fslow, ffast, idac, lowm, act;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] vdac;
    logic [33:0] exp_q[$];
    int n_mismatch = 0, num_checks = 0, c, v, i, lim, n;

    // Clock of 50 ns period
    always #25 clk = ~clk;

    cld_top #(.SLOW_BIT_CYC(20)) dut_u (.clk(clk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .current_ceiling_select(isel), .voltage_ceiling_select(vsel),
        .adapter_above_130(c130), .adapter_above_25(c25), .adapter_below_neg25(cn25),
        .charge_enable_pin_in(pin), .charge_enable_pin_out(), .charge_enable_pin_oe(oe),
        .fet_on(fet_on), .fet_off_slow(fslow), .fet_off_fast(ffast), .vdac_code(vdac),
        .idac_switch(idac), .low_current_mode(lowm), .charging_active(act));

    cld_fe_model fe_u (.diff_mv(diff), .ext_pull_low(ext), .dev_pull_low(oe),
        .cmp_130(c130), .cmp_25(c25), .cmp_neg25(cn25), .pin_level(pin));

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic hang();
        n_mismatch++;
        $display("MISMATCH t=%0t wait ran out", $time);
        print_verdict();
    endtask

    task automatic cmp_bus(input logic [33:0] g, input logic [33:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t bus got %h want %h", $time, g, e);
        end
    endtask

    task automatic cmp_pin(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t pin got %h want %h", $time, g, e);
        end
    endtask

    // Bus answers are matched with the oldest note, reads and writes alike
    always @(posedge clk) begin
        if (bvalid && bready) begin
            cmp_bus({bresp, 32'h0}, exp_q.pop_front());
        end else if (rvalid && rready) begin
            cmp_bus({rresp, rdata}, exp_q.pop_front());
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int k;
        exp_q.push_back({r, 32'h0});
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (k == 50) hang();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int k;
        exp_q.push_back({r, d});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (k == 50) hang();
    endtask

    // Synchronisers and FET state need about four cycles; ten leaves margin
    task automatic setup(input int ic, input int vc, input logic signed [15:0] d);
        @(posedge clk);
        isel <= ic[1:0];
        vsel <= vc[2:0];
        diff <= d;
        repeat (10) @(posedge clk);
    endtask

    function automatic logic [31:0] st(input logic vor, lost, low, p);
        return {21'h0, vsel, 2'h0, isel, p, low, lost, vor};
    endfunction

    task automatic count_on(input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge clk);
            n += idac;
        end
    endtask

    initial begin
        void'($urandom(32'hB3B354EA));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        setup(0, 0, 16'sh0000);
        cmp_pin(oe, 16'h1);
        rd(CLD_REG_STATUS, st(0, 1, 1, 0), CLD_RESP_OKAY);
        rd(8'h20, 32'h0, CLD_RESP_SLVERR);
        wr(CLD_REG_STATUS, 32'h1, CLD_RESP_SLVERR);
        setup(0, 0, 16'sh00C8);
        cmp_pin({fet_on, fslow, ffast, oe}, 16'h8);
        rd(CLD_REG_STATUS, st(0, 0, 1, 1), CLD_RESP_OKAY);
        $display("test reset and input FET done");
        // Voltage classes: random in-range request, then one over the ceiling
        wr(CLD_REG_CURR_REQ, 32'h1F4, CLD_RESP_OKAY);
        for (c = 0; c < 5; c++) begin
            setup(0, c, 16'sh00C8);
            v = CLD_VMIN_MV + 16 * ($urandom % ((CLD_VOLTAGE_CEILING_SELECT_MV[c] - CLD_VMIN_MV) / 16));
            wr(CLD_REG_VOLT_REQ, v, CLD_RESP_OKAY);
            rd(CLD_REG_VDAC, v - CLD_VREF_MV, CLD_RESP_OKAY);
            cmp_pin(vdac, v - CLD_VREF_MV);
            wr(CLD_REG_VOLT_REQ, CLD_VOLTAGE_CEILING_SELECT_MV[c] + 1, CLD_RESP_OKAY);
            rd(CLD_REG_VDAC, CLD_VOLTAGE_CEILING_SELECT_MV[c] - CLD_VREF_MV, CLD_RESP_OKAY);
            rd(CLD_REG_STATUS, st(1, 0, 0, 1), CLD_RESP_OKAY);
        end
        wr(CLD_REG_VOLT_REQ, 32'h3E8, CLD_RESP_OKAY);
        rd(CLD_REG_VDAC, 32'h0, CLD_RESP_OKAY);
        wr(CLD_REG_VOLT_REQ, 32'h1194, CLD_RESP_OKAY);
        $display("test voltage ceilings done");
        // Current classes: random request above low mode, then one over the ceiling
        for (c = 0; c < 4; c++) begin
            setup(c, 4, 16'sh00C8);
            lim = CLD_CURRENT_CEILING_SELECT_MA[c];
            i = lim / 16 + 16 + $urandom % (lim - lim / 16 - 16);
            wr(CLD_REG_CURR_REQ, i, CLD_RESP_OKAY);
            rd(CLD_REG_IDAC, i / CLD_ISTEP_MA[c], CLD_RESP_OKAY);
            wr(CLD_REG_CURR_REQ, lim + 5, CLD_RESP_OKAY);
            rd(CLD_REG_IDAC, lim / CLD_ISTEP_MA[c], CLD_RESP_OKAY);
        end
        setup(0, 4, 16'sh00C8);
        wr(CLD_REG_CURR_REQ, 32'h200, CLD_RESP_OKAY);
        count_on(20);
        count_on(2046);
        cmp_pin(n >= 1018 && n <= 1028, 16'h1);
        $display("test current ceilings done");
        // Low-current mode, its disable bit and wake current in a wider class
        wr(CLD_REG_CURR_REQ, 32'h32, CLD_RESP_OKAY);
        count_on(10);
        cmp_pin(lowm, 16'h1);
        count_on(400);
        cmp_pin(n <= 50, 16'h1);
        wr(CLD_REG_OPTION, 32'h1, CLD_RESP_OKAY);
        count_on(10);
        cmp_pin(lowm, 16'h0);
        setup(2, 4, 16'sh00C8);
        wr(CLD_REG_OPTION, 32'h2, CLD_RESP_OKAY);
        rd(CLD_REG_IDAC, CLD_WAKE_MA / CLD_ISTEP_MA[2], CLD_RESP_OKAY);
        wr(CLD_REG_OPTION, 32'h0, CLD_RESP_OKAY);
        wr(CLD_REG_CURR_REQ, 32'h1F4, CLD_RESP_OKAY);
        $display("test low current mode done");
        // Input FET walk: small margin, reverse, weak recovery, full recovery
        setup(2, 4, 16'sh000A);
        cmp_pin({fet_on, fslow, ffast}, 16'h2);
        setup(2, 4, -16'sh0032);
        cmp_pin({fet_on, fslow, ffast, oe, act}, 16'h06);
        setup(2, 4, 16'sh003C);
        cmp_pin({oe, act}, 16'h2);
        setup(2, 4, 16'sh00C8);
        cmp_pin({fet_on, fslow, ffast, oe, act}, 16'h11);
        cmp_pin(vdac, 16'h0CF4);
        // Outside party holds the pin low, then lets go
        @(posedge clk);
        ext <= 1'b1;
        count_on(10);
        cmp_pin({oe, act}, 16'h0);
        @(posedge clk);
        ext <= 1'b0;
        count_on(10);
        cmp_pin(act, 16'h1);
        cmp_pin(vdac, 16'h0CF4);
        $display("test input FET and pin release done");
        print_verdict();
    end
endmodule
`default_nettype wire
